// [src/aepc_chain.sv]
`timescale 1ns/1ps
`include "aepc_defines.svh"
module aepc_chain
  import aepc_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYC = `AEPC_POR_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic master_clear_n,
  input wire logic supply_low,
  input wire logic smp_valid,
  input wire aepc_sample_t smp_data,
  output logic smp_ready,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic energy_pulse_a,
  output logic energy_pulse_b,
  output logic calibration_pulse
);
  logic chain_rst;
  aepc_ctrl_t ctrl_r, ctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [`AEPC_POR_W-1:0] por_r, por_nxt;
  logic inhibit;
  aepc_state_t st_r, st_nxt;
  aepc_dp_t dp_r, dp_nxt;
  logic pa_r, pa_nxt, pb_r, pb_nxt, pc_r, pc_nxt;
  logic fifo_valid, fifo_pop;
  aepc_sample_t fifo_data, smp_r, smp_nxt;
  logic [16:0] hp_y [2];
  logic signed [33:0] lpf_out;

  // Supply monitor and master clear both act as the same chain reset
  assign chain_rst = sys_rst | ~master_clear_n | supply_low;

  // Input samples arrive at MCLK/256; FIFO absorbs jitter of the source
  aepc_fifo #(
    .WIDTH($bits(aepc_sample_t)),
    .DEPTH(`AEPC_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(chain_rst),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(smp_data),
    .out_valid(fifo_valid),
    .out_ready(st_r == S_IDLE),
    .out_data(fifo_data)
  );
  assign fifo_pop = fifo_valid & (st_r == S_IDLE);

  // Same filter on both channels, stepped by one strobe
  for (genvar ch = 0; ch < 2; ch++) begin : g_hpf
    aepc_hpf u_hpf (
      .mclk(mclk),
      .sys_rst(chain_rst),
      .x((ch == 0) ? smp_r.ch0 : smp_r.ch1),
      .enable(ctrl_r.highpass_enable),
      .step(st_r == S_FILT),
      .y(hp_y[ch])
    );
  end

  assign lpf_out = 34'($signed(dp_r.lpf) >>> `AEPC_LPF_SHIFT);

  function automatic logic [5:0] cal_ratio_log2(input logic [2:0] fs);
    case (fs)
      3'h0: cal_ratio_log2 = 6'h6;
      3'h1: cal_ratio_log2 = 6'h5;
      3'h2: cal_ratio_log2 = 6'h4;
      3'h3: cal_ratio_log2 = 6'hB;
      3'h4: cal_ratio_log2 = 6'h7;
      3'h5: cal_ratio_log2 = 6'h6;
      3'h6: cal_ratio_log2 = 6'h5;
      default: cal_ratio_log2 = 6'h4;
    endcase
  endfunction : cal_ratio_log2

  // Power-up inhibit timer; restarts on every supply dip
  always_comb begin
    por_nxt = por_r;
    if (por_r != '0) begin
      por_nxt = por_r - 1'b1;
    end
  end
  assign inhibit = (por_r != '0);

  always_ff @(posedge mclk) begin
    if (sys_rst || supply_low) begin
      por_r <= `AEPC_POR_W'(POR_HOLD_CYC);
    end else begin
      por_r <= por_nxt;
    end
  end

  // Processing sequence and energy-to-pulse conversion
  always_comb begin
    logic [5:0] sh_e;
    logic [5:0] sh_c;
    logic [47:0] thr_e;
    logic [47:0] thr_c;
    logic [47:0] inc;
    logic [47:0] sum_e;
    logic [47:0] sum_c;
    logic noload;
    sh_e = `AEPC_E_SHIFT_MAX - {4'h0, ctrl_r.freq_select[1:0]};
    sh_c = sh_e - cal_ratio_log2(ctrl_r.freq_select);
    thr_e = 48'h1 << sh_e;
    thr_c = 48'h1 << sh_c;
    noload = (lpf_out < $signed(`AEPC_NOLOAD_MIN))
      && (ctrl_r.freq_select != `AEPC_FSEL_NOLOAD_OFF);
    inc = (lpf_out > 0) ? 48'(lpf_out) : 48'h0;
    sum_e = dp_r.acc_e + inc;
    sum_c = dp_r.acc_c + inc;
    st_nxt = st_r;
    dp_nxt = dp_r;
    smp_nxt = smp_r;
    pa_nxt = 1'b0;
    pb_nxt = 1'b0;
    pc_nxt = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (fifo_pop) begin
          // Unsettled converter output is treated as zero
          if (dp_r.settle != `AEPC_SETTLE_SAMPLES) begin
            smp_nxt = '0;
            dp_nxt.settle = dp_r.settle + 2'h1;
          end else begin
            smp_nxt = fifo_data;
          end
          st_nxt = S_FILT;
        end
      end
      S_FILT: begin
        dp_nxt.hp0 = hp_y[0];
        dp_nxt.hp1 = hp_y[1];
        st_nxt = S_MUL;
      end
      S_MUL: begin
        dp_nxt.prod = 34'($signed(dp_r.hp0) * $signed(dp_r.hp1));
        st_nxt = S_LPF;
      end
      S_LPF: begin
        dp_nxt.lpf = 42'($signed(dp_r.lpf) + 42'($signed(dp_r.prod))
          - 42'(lpf_out));
        st_nxt = S_ACC;
      end
      S_ACC: begin
        if (!noload) begin
          dp_nxt.acc_e = sum_e;
          dp_nxt.acc_c = sum_c;
          if (sum_e >= thr_e) begin
            dp_nxt.acc_e = sum_e - thr_e;
            dp_nxt.side = ~dp_r.side;
            dp_nxt.ecnt = dp_r.ecnt + 32'h1;
            // Inhibit drops pulses only; energy keeps accumulating
            pa_nxt = ~inhibit & ~dp_r.side;
            pb_nxt = ~inhibit & dp_r.side;
          end
          if (sum_c >= thr_c) begin
            dp_nxt.acc_c = sum_c - thr_c;
            pc_nxt = ~inhibit;
          end
        end
        st_nxt = S_IDLE;
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (chain_rst) begin
      st_r <= S_IDLE;
      dp_r <= '0;
      smp_r <= '0;
      pa_r <= 1'b0;
      pb_r <= 1'b0;
      pc_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dp_r <= dp_nxt;
      smp_r <= smp_nxt;
      pa_r <= pa_nxt;
      pb_r <= pb_nxt;
      pc_r <= pc_nxt;
    end
  end

  assign energy_pulse_a = pa_r;
  assign energy_pulse_b = pb_r;
  assign calibration_pulse = pc_r;

  // Avalon slave: one wait cycle per access, read data registered
  always_comb begin
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    if (avs_write && ack_r && avs_address == `AEPC_REG_CTRL && avs_byteenable[0]) begin
      ctrl_nxt.highpass_enable = avs_writedata[`AEPC_CTRL_HPF_BIT];
      ctrl_nxt.freq_select = avs_writedata[`AEPC_CTRL_FSEL_MSB:`AEPC_CTRL_FSEL_LSB];
    end
    if (avs_read && !ack_r) begin
      case (avs_address)
        `AEPC_REG_CTRL: rdata_nxt = {28'h0, ctrl_r};
        `AEPC_REG_STATUS: rdata_nxt = {27'h0, ~smp_ready,
          (dp_r.settle == `AEPC_SETTLE_SAMPLES), st_r != S_IDLE, inhibit, chain_rst};
        `AEPC_REG_POWER: rdata_nxt = lpf_out[33:2];
        `AEPC_REG_ECOUNT: rdata_nxt = dp_r.ecnt;
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      ctrl_r <= `AEPC_CTRL_RESET;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
endmodule : aepc_chain

// [src/aepc_defines.svh]
`ifndef AEPC_DEFINES_SVH
`define AEPC_DEFINES_SVH

// Register byte offsets
`define AEPC_REG_CTRL 5'h00
`define AEPC_REG_STATUS 5'h04
`define AEPC_REG_POWER 5'h08
`define AEPC_REG_ECOUNT 5'h0C
`define AEPC_CTRL_RESET 4'h1

// Field positions
`define AEPC_CTRL_HPF_BIT 0
`define AEPC_CTRL_FSEL_LSB 1
`define AEPC_CTRL_FSEL_MSB 3

// Filter shifts: 2^9 gives ~4.4 Hz, 2^8 gives ~8.7 Hz at MCLK/256
`define AEPC_HPF_SHIFT 9
`define AEPC_LPF_SHIFT 8

// Energy threshold shift for select 00; 01..11 step down by one
`define AEPC_E_SHIFT_MAX 6'h2B
`define AEPC_ACC_W 48

// No-load floor: 0.0015 % of full-scale product
`define AEPC_NOLOAD_PPM 15
`define AEPC_NOLOAD_MIN (34'((64'h1 << 30) * `AEPC_NOLOAD_PPM / 1000000))
`define AEPC_FSEL_NOLOAD_OFF 3'h3

// Samples discarded while the converters settle
`define AEPC_SETTLE_SAMPLES 2'h3

// Power-up pulse inhibit
`define AEPC_POR_HOLD_MS 1000
`define AEPC_CLK_KHZ 200000
`define AEPC_POR_HOLD_CYC (`AEPC_POR_HOLD_MS * `AEPC_CLK_KHZ)
`define AEPC_POR_W 28

`define AEPC_FIFO_DEPTH 4

`endif

// [src/aepc_fifo.sv]
`timescale 1ns/1ps
module aepc_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rd_r];

  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (push) begin
      wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : PW'(wr_r + 1'b1);
    end
    if (pop) begin
      rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : PW'(rd_r + 1'b1);
    end
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule : aepc_fifo

// [src/aepc_hpf.sv]
`timescale 1ns/1ps
`include "aepc_defines.svh"
module aepc_hpf (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] x,
  input wire logic enable,
  input wire logic step,
  output logic [16:0] y
);
  // DC estimate kept with extra fraction bits so tiny offsets still converge
  logic signed [31:0] dc_r, dc_nxt;
  logic signed [16:0] xs;

  assign xs = 17'($signed(x));

  always_comb begin
    if (enable) begin
      y = 17'(xs - 17'(dc_r >>> `AEPC_HPF_SHIFT));
    end else begin
      y = xs;
    end
    dc_nxt = dc_r;
    if (step && enable) begin
      dc_nxt = dc_r + 32'($signed(y));
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dc_r <= '0;
    end else begin
      dc_r <= dc_nxt;
    end
  end
endmodule : aepc_hpf

// [src/aepc_pkg.sv]
package aepc_pkg;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } aepc_sample_t;

  typedef struct packed {
    logic [2:0] freq_select;
    logic highpass_enable;
  } aepc_ctrl_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_FILT = 5'h02,
    S_MUL = 5'h04,
    S_LPF = 5'h08,
    S_ACC = 5'h10
  } aepc_state_t;

  typedef struct packed {
    logic [16:0] hp0;
    logic [16:0] hp1;
    logic [33:0] prod;
    logic [41:0] lpf;
    logic [47:0] acc_e;
    logic [47:0] acc_c;
    logic [1:0] settle;
    logic side;
    logic [31:0] ecnt;
  } aepc_dp_t;

endpackage : aepc_pkg

// [verif/aepc_chain_sva.sv]
`timescale 1ns/1ps
module aepc_chain_sva #(
  parameter int unsigned POR_HOLD_CYC = 50
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic master_clear_n,
  input wire logic supply_low,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic energy_pulse_a,
  input wire logic energy_pulse_b,
  input wire logic calibration_pulse
);
  logic [31:0] up_r;
  logic [31:0] up_nxt;
  logic any_p;
  assign any_p = energy_pulse_a | energy_pulse_b | calibration_pulse;
  // Saturates, so a long run cannot wrap back into the inhibit span
  always_comb begin
    up_nxt = up_r;
    if (sys_rst || supply_low) up_nxt = 32'h0;
    else if (up_r < POR_HOLD_CYC) up_nxt = up_r + 32'h1;
  end
  always_ff @(posedge mclk) begin
    up_r <= up_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_req; $rose(avs_read || avs_write); endsequence
  sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  a_bus_one_wait: assert property (s_req |-> s_one_wait)
    else $error("bus answer not after one wait");
  a_pulse_a_single: assert property (energy_pulse_a |=> !energy_pulse_a)
    else $error("pulse a too long");
  a_cal_single: assert property (calibration_pulse |=> !calibration_pulse)
    else $error("calibration pulse too long");
  a_ab_exclusive: assert property (!(energy_pulse_a && energy_pulse_b))
    else $error("both energy outputs high");
  a_clear_quiet: assert property ((!master_clear_n)[*2] |-> !any_p)
    else $error("pulse during master clear");
  a_supply_quiet: assert property (supply_low[*2] |-> !any_p)
    else $error("pulse during low supply");
  a_por_inhibit: assert property (any_p |-> up_r >= POR_HOLD_CYC - 1)
    else $error("pulse inside power-up inhibit");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[4]
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule : aepc_chain_sva

bind aepc_chain aepc_chain_sva #(.POR_HOLD_CYC(POR_HOLD_CYC)) u_aepc_chain_sva (
  .mclk, .sys_rst, .master_clear_n, .supply_low, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .energy_pulse_a, .energy_pulse_b, .calibration_pulse);

// [verif/aepc_pulse_counter.sv]
`timescale 1ns/1ps
module aepc_pulse_counter (
  input wire logic mclk,
  input wire logic resync,
  input wire logic energy_pulse_a,
  input wire logic energy_pulse_b,
  input wire logic calibration_pulse,
  output logic [15:0] count_e,
  output logic [15:0] count_c,
  output logic phase_err
);
  // Two-phase stepper: the same coil twice would step it backwards
  logic seen;
  logic last_a;
  initial begin
    phase_err = 1'b0;
  end
  always @(posedge mclk) begin
    if (resync) begin
      count_e <= 16'h0;
      count_c <= 16'h0;
      seen <= 1'b0;
    end else begin
      if (energy_pulse_a || energy_pulse_b) begin
        if (seen && energy_pulse_a == last_a) phase_err <= 1'b1;
        seen <= 1'b1;
        last_a <= energy_pulse_a;
        count_e <= count_e + 16'h1;
      end
      if (calibration_pulse) count_c <= count_c + 16'h1;
    end
  end
endmodule : aepc_pulse_counter

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import aepc_pkg::*;
  logic mclk;
  logic sys_rst;
  logic master_clear_n;
  logic supply_low;
  logic smp_valid;
  aepc_sample_t smp_data;
  logic smp_ready;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic energy_pulse_a;
  logic energy_pulse_b;
  logic calibration_pulse;
  logic [15:0] count_e;
  logic [15:0] count_c;
  logic phase_err;
  logic [31:0] seed = 32'h00011057;
  int n_mismatch = 0;
  int tests_run = 0;

  aepc_chain #(.POR_HOLD_CYC(50)) u_aepc_chain (.mclk, .sys_rst, .master_clear_n,
    .supply_low, .smp_valid, .smp_data, .smp_ready, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .energy_pulse_a,
    .energy_pulse_b, .calibration_pulse);
  aepc_pulse_counter u_aepc_pulse_counter (.mclk,
    .resync(sys_rst || !master_clear_n || supply_low), .energy_pulse_a, .energy_pulse_b,
    .calibration_pulse, .count_e, .count_c, .phase_err);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] ctrl_exp(input logic [31:0] old, input logic [31:0] wd,
    input logic [3:0] be);
    return be[0] ? {28'h0, wd[3:0]} : old;
  endfunction : ctrl_exp

  // Calibration step is one sixteenth of the energy step for select 111
  function automatic logic [31:0] ratio_ok(input logic [15:0] e, input logic [15:0] c);
    return (e != 16'h0 && {4'h0, c} >= {e, 4'h0} && {4'h0, c} <= {e, 4'hF}) ? 32'h1 : 32'h0;
  endfunction : ratio_ok

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : cmp

  task automatic run(input int n);
    repeat (n) @(posedge mclk);
  endtask : run

  // Request stands until waitrequest is seen low at a rising edge; data taken there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) cmp(32'h1, 32'h0, "bus hang");
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One idle edge so the next call never reassigns in this time step
    @(posedge mclk);
  endtask : bus

  task automatic clear_chain();
    master_clear_n <= 1'b0;
    run(4);
    master_clear_n <= 1'b1;
    smp_valid <= 1'b1;
  endtask : clear_chain

  task automatic check_count();
    logic [31:0] q;
    smp_valid <= 1'b0;
    // Full FIFO plus one word in flight needs 25 cycles to drain
    run(40);
    bus(1'b0, 5'h0C, 32'h0, 4'hF, q);
    cmp(q, {16'h0, count_e}, "pulse count");
  endtask : check_count

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (80000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end

  initial begin : main
    logic [31:0] q;
    logic [31:0] ctrl;
    logic [31:0] wd;
    logic [3:0] be;
    sys_rst = 1'b1;
    master_clear_n = 1'b1;
    supply_low = 1'b0;
    smp_valid = 1'b1;
    smp_data = 32'h7FFF7FFF;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    run(10);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, 5'h00, 32'h0, 4'hF, q);
    cmp(q, 32'h1, "control reset");
    ctrl = 32'h1;
    for (int i = 0; i < 8; i++) begin
      wd = rnd();
      be = {wd[7:5], i[0]};
      bus(1'b1, 5'h00, wd, be, q);
      ctrl = ctrl_exp(ctrl, wd, be);
      bus(1'b0, 5'h00, 32'h0, 4'hF, q);
      cmp(q, ctrl, "control readback");
    end
    bus(1'b1, 5'h14, 32'hFFFFFFFF, 4'hF, q);
    bus(1'b0, 5'h14, 32'h0, 4'hF, q);
    cmp(q, 32'h0, "unmapped read");
    bus(1'b0, 5'h00, 32'h0, 4'hF, q);
    cmp(q, ctrl, "control after unmapped write");
    wd = rnd();
    smp_data <= {2{8'h7F, wd[7:0]}};
    bus(1'b1, 5'h00, 32'hE, 4'h1, q);
    clear_chain();
    run(30000);
    check_count();
    cmp(ratio_ok(count_e, count_c), 32'h1, "calibration ratio");
    cmp({31'h0, phase_err}, 32'h0, "stepper phase");
    bus(1'b1, 5'h00, 32'hF, 4'h1, q);
    clear_chain();
    run(20000);
    wd = {count_e, count_c};
    run(5000);
    cmp({count_e, count_c}, wd, "offset removed");
    check_count();
    supply_low <= 1'b1;
    run(5);
    supply_low <= 1'b0;
    run(5);
    bus(1'b0, 5'h0C, 32'h0, 4'hF, q);
    cmp(q, 32'h0, "count after supply drop");
    bus(1'b0, 5'h04, 32'h0, 4'hF, q);
    cmp(q, 32'h2, "inhibit after supply drop");
    run(60);
    bus(1'b0, 5'h04, 32'h0, 4'hF, q);
    cmp(q, 32'h0, "inhibit expired");
    conclude();
  end
endmodule : tb
